// ---- logic/macrocell_pkg.sv ----
`default_nettype none
package macrocell_pkg;

  localparam int NUM_CELLS   = 10;
  localparam int MAX_PTERMS  = 16;
  localparam int BASE_PTERMS = 8;
  localparam int PTERM_STEP  = 2;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int CFG_W       = 4;
  localparam int SYNC_STAGES = 3;

  // Register map, byte addresses of aligned words
  localparam logic [ADDR_W-1:0] CFG_BASE_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_STRIDE   = 8'h04;
  localparam logic [ADDR_W-1:0] STATE_OFF    = 8'h28;
  localparam logic [ADDR_W-1:0] PIN_OFF      = 8'h2C;
  localparam int                PIN_OE_LSB   = 16;

  typedef enum logic [1:0] {OE_ON, OE_OFF, OE_PTERM, OE_RSVD} oe_sel_t;

  // Bit b: 1 combinatorial, 0 registered; bit a: 1 true, 0 inverted
  typedef struct packed {
    logic    cell_cfg_bit_b;
    logic    cell_cfg_bit_a;
    oe_sel_t oe_sel;
  } cell_cfg_t;

  localparam cell_cfg_t CFG_RESET = '{cell_cfg_bit_b: 1'b1,
                                      cell_cfg_bit_a: 1'b1,
                                      oe_sel:         OE_OFF};

  typedef struct packed {
    logic drive;
    logic oe;
    logic fb_true;
    logic fb_comp;
  } cell_pin_t;

  // Pairs from both ends of the row share a term count
  function automatic int pterm_count(input int idx);
    int pair;
    pair = (idx < NUM_CELLS - 1 - idx) ? idx : NUM_CELLS - 1 - idx;
    return BASE_PTERMS + PTERM_STEP * pair;
  endfunction

endpackage
`default_nettype wire

// ---- logic/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import macrocell_pkg::*;
#(
  parameter int WIDTH = NUM_CELLS
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Pin levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is taken only once the last two stages agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/output_macrocell.sv ----
`timescale 1ns/100ps
`default_nettype none
module output_macrocell
  import macrocell_pkg::*;
#(
  parameter int NUM_PT = BASE_PTERMS
) (
  // Array side
  input  wire logic [MAX_PTERMS-1:0] pterms,
  input  wire logic                  oe_term,
  input  wire cell_cfg_t             cfg,
  // Register state after clear
  input  wire logic                  q_eff,
  // Synchronised pin level
  input  wire logic                  pin_level,
  // Results
  output logic                       sum,
  output cell_pin_t                  pins
);

  logic drive_src;
  logic pin_side;
  logic oe_c;

  assign sum       = |pterms[NUM_PT-1:0];                           // see RL1 see RL15
  assign drive_src = cfg.cell_cfg_bit_b ? sum : q_eff;              // see RL8 see RL12
  assign pins.drive = cfg.cell_cfg_bit_a ? drive_src : ~drive_src;  // see RL3 see RL6

  // Local enable keeps every struct member under a single driver kind
  always_comb begin
    if (!cfg.cell_cfg_bit_b) begin
      oe_c = oe_term;                                               // see RL2 see RL11
    end else begin
      case (cfg.oe_sel)                                             // see RL13
        OE_ON:    oe_c = 1'b1;
        OE_PTERM: oe_c = oe_term;
        default:  oe_c = 1'b0;
      endcase
    end
  end

  assign pins.oe = oe_c;

  // Pin side of the buffer: own drive when enabled, else outside level
  assign pin_side = pins.oe ? pins.drive : pin_level;

  // Registered cells return the inverted register, never the pin
  assign pins.fb_true = cfg.cell_cfg_bit_b ? pin_side : ~q_eff;    // see RL9 see RL10 see RL14
  assign pins.fb_comp = ~pins.fb_true;

endmodule
`default_nettype wire

// ---- logic/macrocell_array.sv ----
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1 - Ten cells, pairs of 8 to 16 terms
// RL2 - Each cell has its own enable term
// RL3 - Pin polarity chosen per cell
// RL4 - Clear term zeroes registers at once
// RL5 - Set term loads ones at next edge
// RL6 - Clear and set ignore polarity
// RL7 - Two bits pick mode and polarity
// RL8 - Registered pin follows its flip-flop
// RL9 - Registered feedback is inverted flip-flop
// RL10 - Registered pin is output only
// RL11 - Registered enable follows its term
// RL12 - Combinatorial pin follows the sum term
// RL13 - Combinatorial enable on, off or term
// RL14 - Combinatorial feedback taken from pin
// RL15 - Common clock; sum is OR of terms
// RL16 - Clear beats set at one edge
module macrocell_array
  import macrocell_pkg::*;
(
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst,
  // Register port
  input  wire logic [ADDR_W-1:0]                     reg_addr,
  input  wire logic [DATA_W-1:0]                     reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [DATA_W-1:0]                     reg_rdata,
  // Product terms from the array
  input  wire logic [NUM_CELLS-1:0][MAX_PTERMS-1:0]  cell_pterms,
  input  wire logic [NUM_CELLS-1:0]                  cell_oe_terms,
  input  wire logic                                  shared_async_clear_term,
  input  wire logic                                  shared_sync_set_term,
  // Pins
  input  wire logic [NUM_CELLS-1:0]                  pin_i,
  output logic      [NUM_CELLS-1:0]                  pin_o,
  output logic      [NUM_CELLS-1:0]                  pin_oe,
  // Feedback to the array
  output logic      [NUM_CELLS-1:0]                  fb_true,
  output logic      [NUM_CELLS-1:0]                  fb_comp
);

  cell_cfg_t              cfg_q [NUM_CELLS];
  logic [NUM_CELLS-1:0]   state_q;
  logic [NUM_CELLS-1:0]   state_d;
  logic [NUM_CELLS-1:0]   q_eff;
  logic [NUM_CELLS-1:0]   sum_vec;
  logic [NUM_CELLS-1:0]   pin_sync_lvl;
  logic [NUM_CELLS-1:0]   pin_level;
  cell_pin_t              cell_pins [NUM_CELLS];
  logic [NUM_CELLS-1:0]   reg_mask;
  logic [NUM_CELLS-1:0]   pol_mask;
  logic [NUM_CELLS-1:0]   oe_on_mask;
  logic [NUM_CELLS-1:0]   oe_off_mask;
  logic [NUM_CELLS-1:0]   oe_term_mask;
  logic [DATA_W-1:0]      rdata_d;
  logic [DATA_W-1:0]      reg_rdata_q;

  // Address decoding
  function automatic logic cfg_hit(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - CFG_BASE_OFF;
    return (addr >= CFG_BASE_OFF)
        && (rel < ADDR_W'(NUM_CELLS) * CFG_STRIDE)
        && (rel % CFG_STRIDE == '0);
  endfunction

  function automatic int cfg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - CFG_BASE_OFF;
    return int'(rel / CFG_STRIDE);
  endfunction

  // Configuration registers, one word per cell
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CELLS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (reg_wr && cfg_hit(reg_addr)) begin
      cfg_q[cfg_index(reg_addr)] <= cell_cfg_t'(reg_wdata[CFG_W-1:0]);  // see RL7
    end
  end

  // Per-cell configuration as flat masks
  always_comb begin
    reg_mask     = '0;
    pol_mask     = '0;
    oe_on_mask   = '0;
    oe_off_mask  = '0;
    oe_term_mask = '0;
    for (int i = 0; i < NUM_CELLS; i++) begin
      reg_mask[i]     = ~cfg_q[i].cell_cfg_bit_b;
      pol_mask[i]     = cfg_q[i].cell_cfg_bit_a;
      oe_on_mask[i]   = cfg_q[i].oe_sel == OE_ON;
      oe_off_mask[i]  = (cfg_q[i].oe_sel == OE_OFF) || (cfg_q[i].oe_sel == OE_RSVD);
      oe_term_mask[i] = cfg_q[i].oe_sel == OE_PTERM;
    end
  end

  // Macrocell registers on the common clock
  always_comb begin
    if (shared_async_clear_term) begin
      state_d = '0;                                                 // see RL16
    end else if (shared_sync_set_term) begin
      state_d = '1;                                                 // see RL5
    end else begin
      state_d = sum_vec;                                            // see RL8
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;                                           // see RL15
    end
  end

  // Clear acts without waiting for an edge
  assign q_eff = shared_async_clear_term ? '0 : state_q;           // see RL4 see RL6

  pin_sync #(
    .WIDTH (NUM_CELLS)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (pin_i),
    .sync_out (pin_sync_lvl)
  );

  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
    output_macrocell #(
      .NUM_PT (pterm_count(g))
    ) u_cell (
      .pterms    (cell_pterms[g]),
      .oe_term   (cell_oe_terms[g]),
      .cfg       (cfg_q[g]),
      .q_eff     (q_eff[g]),
      .pin_level (pin_sync_lvl[g]),
      .sum       (sum_vec[g]),
      .pins      (cell_pins[g])
    );
    assign pin_o[g]     = cell_pins[g].drive;
    assign pin_oe[g]    = cell_pins[g].oe;
    assign fb_true[g]   = cell_pins[g].fb_true;
    assign fb_comp[g]   = cell_pins[g].fb_comp;
    assign pin_level[g] = cell_pins[g].oe ? cell_pins[g].drive : pin_sync_lvl[g];
  end

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (!reg_rd) begin
      rdata_d = '0;
    end else if (cfg_hit(reg_addr)) begin
      rdata_d[CFG_W-1:0] = cfg_q[cfg_index(reg_addr)];
    end else if (reg_addr == STATE_OFF) begin
      rdata_d[NUM_CELLS-1:0] = q_eff;
    end else if (reg_addr == PIN_OFF) begin
      rdata_d[NUM_CELLS-1:0]                    = pin_level;
      rdata_d[PIN_OE_LSB +: NUM_CELLS]          = pin_oe;
    end else begin
      rdata_d = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_clear_zero;  // see RL4
    shared_async_clear_term |-> (q_eff == '0)
      ##1 (state_q == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero)  // see RL4
    else $error("clear term did not zero registers");

  property p_set_ones;  // see RL5
    (shared_sync_set_term && !shared_async_clear_term)
      |=> (state_q == '1);
  endproperty
  a_set_ones: assert property (p_set_ones)  // see RL5
    else $error("set term did not load ones");

  property p_clear_wins;  // see RL16
    (shared_async_clear_term && shared_sync_set_term)
      |=> (state_q == '0);
  endproperty
  a_clear_wins: assert property (p_clear_wins)  // see RL16
    else $error("set won over clear");

  property p_sample_sum;  // see RL15
    (!shared_async_clear_term && !shared_sync_set_term)
      |=> (state_q == $past(sum_vec));
  endproperty
  a_sample_sum: assert property (p_sample_sum)  // see RL15
    else $error("register missed the sum term");

  property p_sum_width;  // see RL1
    (sum_vec[0] == |cell_pterms[0][BASE_PTERMS-1:0])
      && (sum_vec[NUM_CELLS/2-1] == |cell_pterms[NUM_CELLS/2-1]);
  endproperty
  a_sum_width: assert property (p_sum_width)  // see RL1
    else $error("sum term uses wrong product terms");

  property p_reg_drive;  // see RL8
    ((pin_o ~^ {NUM_CELLS{1'b1}} ^ ~pol_mask ^ q_eff) & reg_mask) == '0
      ##0 (((pin_o ^ q_eff) & reg_mask) == (~pol_mask & reg_mask));
  endproperty
  a_reg_drive: assert property (p_reg_drive)  // see RL8
    else $error("registered pin not following register");

  property p_comb_drive;  // see RL12
    (((pin_o ^ sum_vec) & ~reg_mask) == (~pol_mask & ~reg_mask));
  endproperty
  a_comb_drive: assert property (p_comb_drive)  // see RL12
    else $error("combinatorial pin not following sum");

  property p_reg_oe;  // see RL11
    ((pin_oe ^ cell_oe_terms) & reg_mask) == '0;
  endproperty
  a_reg_oe: assert property (p_reg_oe)  // see RL11
    else $error("registered enable not following its term");

  property p_comb_oe;  // see RL13
    ((pin_oe & oe_off_mask & ~reg_mask) == '0)
      && ((~pin_oe & oe_on_mask & ~reg_mask) == '0)
      && (((pin_oe ^ cell_oe_terms) & oe_term_mask & ~reg_mask) == '0);
  endproperty
  a_comb_oe: assert property (p_comb_oe)  // see RL13
    else $error("combinatorial enable select broken");

  property p_reg_fb;  // see RL9
    (((fb_true ^ ~q_eff) & reg_mask) == '0) && ((fb_true ^ fb_comp) == '1);
  endproperty
  a_reg_fb: assert property (p_reg_fb)  // see RL9
    else $error("registered feedback not inverted register");

  property p_comb_fb;  // see RL14
    (((fb_true ^ pin_level) & ~reg_mask) == '0);
  endproperty
  a_comb_fb: assert property (p_comb_fb)  // see RL14
    else $error("combinatorial feedback not from pin");

  property p_state_read;
    (reg_rd && reg_addr == STATE_OFF)
      |=> (reg_rdata[NUM_CELLS-1:0] == $past(q_eff));
  endproperty
  a_state_read: assert property (p_state_read)  // see RL4
    else $error("state read returned wrong value");

endmodule
`default_nettype wire

// ---- verification/board_pins.sv ----
`timescale 1ns/100ps
`default_nettype none
module board_pins
  import macrocell_pkg::*;
(
  // Clock
  input  wire logic                 clk_sys,
  // Device side
  input  wire logic [NUM_CELLS-1:0] pin_o,
  input  wire logic [NUM_CELLS-1:0] pin_oe,
  // Board drivers
  input  wire logic [NUM_CELLS-1:0] ext_en,
  input  wire logic [NUM_CELLS-1:0] ext_val,
  // Resolved wire level
  output logic      [NUM_CELLS-1:0] pin_i
);
  logic [NUM_CELLS-1:0] last_q;

  initial begin
    last_q = '0;
  end

  // Undriven lines toggle so that a stale level never looks valid
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (pin_oe[i]) begin
        pin_i[i] = pin_o[i];
      end else if (ext_en[i]) begin
        pin_i[i] = ext_val[i];
      end else begin
        pin_i[i] = ~last_q[i];
      end
    end
  end

  always @(posedge clk_sys) begin
    last_q <= pin_i;
  end
endmodule
`default_nettype wire

// ---- verification/tb_programmable_output_macrocells.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_programmable_output_macrocells
  import macrocell_pkg::*;
();
  localparam int NPT [NUM_CELLS] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  logic                                 clk_sys, rst, reg_wr, reg_rd, m_rdp, e;
  logic                                 shared_async_clear_term, shared_sync_set_term;
  logic [ADDR_W-1:0]                    reg_addr;
  logic [DATA_W-1:0]                    reg_wdata, reg_rdata, m_rd, m_msk;
  logic [NUM_CELLS-1:0][MAX_PTERMS-1:0] cell_pterms;
  logic [NUM_CELLS-1:0]                 cell_oe_terms, pin_i, pin_o, pin_oe, fb_true, fb_comp;
  logic [NUM_CELLS-1:0]                 ext_en, ext_val, m_st, prev_pin;
  logic [3:0]                           m_cfg [NUM_CELLS];
  int                                   stab [NUM_CELLS];
  int                                   err_count, comparisons, seed;

  macrocell_array dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cell_pterms(cell_pterms), .cell_oe_terms(cell_oe_terms),
    .shared_async_clear_term(shared_async_clear_term),
    .shared_sync_set_term(shared_sync_set_term), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .fb_true(fb_true), .fb_comp(fb_comp));
  board_pins partner (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic sum_of(input int i);
    logic [16:0] m;
    m = (17'h1 << NPT[i]) - 17'h1;
    return |(cell_pterms[i] & m[15:0]);
  endfunction

  function automatic logic [NUM_CELLS-1:0] eff_state();
    return shared_async_clear_term ? '0 : m_st;
  endfunction

  function automatic logic exp_po(input int i);
    logic s;
    s = m_cfg[i][3] ? sum_of(i) : eff_state() >> i;
    return m_cfg[i][2] ? s : ~s;
  endfunction

  function automatic logic exp_oe(input int i);
    if (!m_cfg[i][3]) return cell_oe_terms[i];
    if (m_cfg[i][1:0] == 2'h0) return 1'b1;
    if (m_cfg[i][1:0] == 2'h2) return cell_oe_terms[i];
    return 1'b0;
  endfunction

  function automatic logic [DATA_W-1:0] rd_value(input logic [ADDR_W-1:0] a);
    logic [NUM_CELLS-1:0] v;
    for (int i = 0; i < NUM_CELLS; i++) v[i] = exp_oe(i);
    if (a[1:0] != 2'h0) return '0;
    if (a < STATE_OFF) return {28'h0, m_cfg[a[7:2]]};
    if (a == STATE_OFF) return {22'h0, eff_state()};
    if (a == PIN_OFF) return {6'h0, v, 16'h0};
    return '0;
  endfunction

  function automatic logic [ADDR_W-1:0] pick(input logic [3:0] s);
    if (s < 4'hC) return {2'h0, s, 2'h0};
    return (s == 4'hC) ? 8'h30 : (s == 4'hD) ? 8'h01 : 8'hFC;
  endfunction

  // Reference model of the registers, updated at each clock edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CELLS; i++) m_cfg[i] = 4'hD;
      m_st = '0;
      m_rdp = 1'b0;
    end else begin
      check(reg_rdata & m_msk, m_rdp ? m_rd : '0);
      m_rdp = reg_rd;
      m_rd = rd_value(reg_addr);
      m_msk = (reg_addr == PIN_OFF) ? 32'h03FF0000 : 32'hFFFFFFFF;
      if (reg_wr && reg_addr < STATE_OFF && reg_addr[1:0] == 2'h0) begin
        m_cfg[reg_addr[7:2]] = reg_wdata[3:0];
      end
      for (int i = 0; i < NUM_CELLS; i++) begin
        m_st[i] = shared_async_clear_term ? 1'b0 : shared_sync_set_term | sum_of(i);
      end
    end
  end

  // Pin and feedback outputs are compared once settled
  always @(negedge clk_sys) begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      stab[i] = (rst || pin_i[i] !== prev_pin[i]) ? 0 : stab[i] + 1;
      check(pin_o[i], exp_po(i));
      check(pin_oe[i], exp_oe(i));
      e = eff_state() >> i;
      if (!m_cfg[i][3]) begin
        check({fb_true[i], fb_comp[i]}, {~e, e});
      end else if (exp_oe(i)) begin
        check({fb_true[i], fb_comp[i]}, {exp_po(i), ~exp_po(i)});
      end else if (stab[i] > 5) begin
        check({fb_true[i], fb_comp[i]}, {pin_i[i], ~pin_i[i]});
      end
    end
    prev_pin = pin_i;
  end

  task automatic drive(input int n);
    logic [31:0] r, t;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys);
      for (int i = 0; i < NUM_CELLS; i++) begin
        t = $random(seed) & $random(seed) & $random(seed);
        cell_pterms[i] <= t[15:0];
      end
      r = $random(seed);
      shared_async_clear_term <= (r[3:0] == 4'h0);
      shared_sync_set_term <= (r[6:4] == 3'h0);
      reg_wr <= (r[8:7] == 2'h1);
      reg_rd <= (r[8:7] == 2'h2);
      reg_addr <= pick(r[13:10]);
      reg_wdata <= $random(seed);
      if (k % 16 == 0) begin
        t = $random(seed);
        cell_oe_terms <= t[9:0];
        ext_en <= t[19:10];
        ext_val <= t[29:20];
      end
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    seed = 32'h7ec1d59b;
    err_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, shared_async_clear_term, shared_sync_set_term} = 4'h0;
    reg_addr = '0;
    reg_wdata = '0;
    cell_pterms = '0;
    {cell_oe_terms, ext_en, ext_val} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    drive(3000);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    drive(1500);
    complete_run();
  end
endmodule
`default_nettype wire
